// >>> rtl/mdio_frame_slave.sv
`timescale 1ns/1ns
`include "phy_regs_defines.svh"
module mdio_frame_slave
   import phy_regs_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic mdc_i,
   input  wire logic mdio_i,
   output logic      mdio_o,
   output logic      mdio_oe_o,
   mgmt_if.slave     bus
);
   logic        mdc_s1;
   logic        mdc_s2;
   logic        mdc_d;
   logic        mdio_s1;
   logic        mdio_s2;
   mdio_state_e state;
   logic [4:0]  cnt;
   logic [5:0]  pre_cnt;
   logic [11:0] hdr;
   logic [15:0] sh;
   logic        is_rd;

   // pins cross from the mdc domain: two flops before use
   always_ff @(posedge clk_i) begin
      mdc_s1  <= mdc_i;
      mdc_s2  <= mdc_s1;
      mdc_d   <= mdc_s2;
      mdio_s1 <= mdio_i;
      mdio_s2 <= mdio_s1;
   end

   wire        rise     = mdc_s2 & ~mdc_d;
   wire        bitv     = mdio_s2;
   wire [11:0] hdr_next = {hdr[10:0], bitv};
   wire        addr_hit = (hdr_next[9:5] == PHY_ADDR);
   wire        op_rd    = (hdr_next[11:10] == `OP_RD);
   wire        op_wr    = (hdr_next[11:10] == `OP_WR);

   ////////////////////////////////////////////////////////////////////////////
   // frame engine: preamble, start, header, turnaround, data
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state     <= MS_IDLE;
         cnt       <= 5'h00;
         pre_cnt   <= 6'h00;
         hdr       <= 12'h000;
         sh        <= 16'h0000;
         is_rd     <= 1'b0;
         mdio_o    <= 1'b0;
         mdio_oe_o <= 1'b0;
         bus.rd    <= 1'b0;
         bus.wr    <= 1'b0;
         bus.addr  <= 5'h00;
         bus.wdata <= 16'h0000;
      end else begin
         bus.rd <= 1'b0;
         bus.wr <= 1'b0;
         // read data is taken once, right after the header, so it cannot change mid-shift
         if (bus.rd) begin
            sh <= bus.rdata;
         end
         if (rise) begin
            case (state)
               MS_IDLE: begin
                  if (bitv) begin
                     pre_cnt <= (pre_cnt == `PRE_ONES) ? pre_cnt : pre_cnt + 6'h01;
                  end else begin
                     if (pre_cnt == `PRE_ONES) begin
                        state <= MS_START;
                     end
                     pre_cnt <= 6'h00;
                  end
               end
               MS_START: begin
                  cnt   <= 5'h00;
                  state <= bitv ? MS_HDR : MS_IDLE;
               end
               MS_HDR: begin
                  hdr <= hdr_next;
                  cnt <= cnt + 5'h01;
                  if (cnt == `HDR_LAST) begin
                     cnt <= 5'h00;
                     if (addr_hit & (op_rd | op_wr)) begin
                        state    <= MS_TA;
                        is_rd    <= op_rd;
                        bus.addr <= hdr_next[4:0];
                        bus.rd   <= op_rd;
                     end else begin
                        state <= MS_IDLE;
                     end
                  end
               end
               MS_TA: begin
                  if (is_rd) begin
                     mdio_oe_o <= 1'b1;
                     mdio_o    <= 1'b0;
                     cnt       <= 5'h00;
                     state     <= MS_DATA;
                  end else if (cnt == `TA_LAST) begin
                     cnt   <= 5'h00;
                     state <= MS_DATA;
                  end else begin
                     cnt <= cnt + 5'h01;
                  end
               end
               MS_DATA: begin
                  cnt <= cnt + 5'h01;
                  if (is_rd) begin
                     if (cnt == `RD_RELEASE) begin
                        mdio_oe_o <= 1'b0;
                        mdio_o    <= 1'b0;
                        state     <= MS_IDLE;
                     end else begin
                        mdio_o <= sh[15];
                        sh     <= {sh[14:0], 1'b0};
                     end
                  end else begin
                     sh <= {sh[14:0], bitv};
                     if (cnt == `DATA_LAST) begin
                        bus.wr    <= 1'b1;
                        bus.wdata <= {sh[14:0], bitv};
                        state     <= MS_IDLE;
                     end
                  end
               end
               default: begin
                  state <= MS_IDLE;
               end
            endcase
         end
      end
   end
endmodule // mdio_frame_slave

// >>> rtl/mgmt_if.sv
`timescale 1ns/1ns
interface mgmt_if;
   import phy_regs_pkg::*;
   logic      rd;
   logic      wr;
   reg_addr_t addr;
   reg_word_t wdata;
   reg_word_t rdata;
   modport slave (output rd, output wr, output addr, output wdata, input rdata);
   modport regs  (input rd, input wr, input addr, input wdata, output rdata);
endinterface

// >>> rtl/phy_nextpage_mii_irq_regs.sv
`timescale 1ns/1ns
`include "phy_regs_defines.svh"
// Contract
// - partner acknowledge bit read-only
// - partner message-page flag read-only
// - partner second acknowledge flag read-only
// - partner toggle and message field, reset zero
// - 100 Mb restore: full preamble, else drop byte
// - 100 Mb restore resets from strap 100
// - 10 Mb restore, else strip seven bytes
// - errored-frame counter, 16 bits, clear on read
// - jabber interrupt enable, reset zero
// - receive error interrupt enable, reset zero
// - page received interrupt enable, reset zero
// - parallel detect fault enable, reset zero
// - partner acknowledge interrupt enable, reset zero
// - link down interrupt enable, reset zero
// - remote fault interrupt enable, reset zero
// - event flags low byte, clear on read
module phy_nextpage_mii_irq_regs
   import phy_regs_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESETN_I,
   input  wire logic [2:0]  CONFIG_I,
   input  wire logic        MDC_I,
   input  wire logic        MDIO_I,
   output logic             MDIO_O,
   output logic             MDIO_OE_O,
   input  wire logic [15:0] LP_PAGE_I,
   input  wire logic        LP_PAGE_VLD_I,
   input  wire logic        SPEED_100_I,
   input  wire logic        RX_DV_I,
   input  wire logic [3:0]  RXD_I,
   input  wire logic        RX_ER_I,
   output logic             MII_RX_DV_O,
   output logic [3:0]       MII_RXD_O,
   output logic             MII_RX_ER_O,
   input  wire logic [7:0]  INT_EVENT_I,
   output logic             INTR_N_O
);
   mgmt_if bus ();

   logic [2:0]  cfg_s1;
   logic [2:0]  cfg_s2;
   reg_word_t   np_word;
   logic        r100;
   logic        r10;
   reg_word_t   sym_err;
   logic [7:0]  irq_en;
   logic [7:0]  irq_flg;
   logic        dv_d;
   logic        err_seen;
   logic [3:0]  nib_cnt;
   logic [3:0]  drop_lat;

   ////////////////////////////////////////////////////////////////////////////
   // management serial bus

   mdio_frame_slave #(
      .PHY_ADDR (PHY_ADDR)
   ) u_mdio (
      .clk_i     (CLK_SYS_I),
      .rst_n_i   (RESETN_I),
      .mdc_i     (MDC_I),
      .mdio_i    (MDIO_I),
      .mdio_o    (MDIO_O),
      .mdio_oe_o (MDIO_OE_O),
      .bus       (bus.slave)
   );

   wire hit_np  = (bus.addr == `OFS_NP_WORD);
   wire hit_mii = (bus.addr == `OFS_MII_CTL);
   wire hit_sym = (bus.addr == `OFS_SYM_ERR);
   wire hit_irq = (bus.addr == `OFS_IRQ_CTL);

   wire wr_mii  = bus.wr & hit_mii;
   wire wr_irq  = bus.wr & hit_irq;
   wire rd_sym  = bus.rd & hit_sym;
   wire rd_irq  = bus.rd & hit_irq;

   ////////////////////////////////////////////////////////////////////////////
   // strap capture; pins pass two flops first

   always_ff @(posedge CLK_SYS_I) begin
      cfg_s1 <= CONFIG_I;
      cfg_s2 <= cfg_s1;
   end

   wire strap_r100 = (cfg_s2 == `STRAP_R100);

   ////////////////////////////////////////////////////////////////////////////
   // partner next page word

   // captured as a whole word so a read never mixes two pages
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         np_word <= `NP_WORD_RST;
      end else if (LP_PAGE_VLD_I) begin
         np_word <= LP_PAGE_I;
      end
   end

   wire        np_ack   = np_word[`NP_ACK];
   wire        np_msg   = np_word[`NP_MSG];
   wire        np_ack2  = np_word[`NP_ACK2];
   wire        np_tog   = np_word[`NP_TOG];
   wire [10:0] np_fld   = np_word[`NP_FLD_HI:0];
   wire [15:0] np_rdata = {np_word[15], np_ack, np_msg, np_ack2, np_tog, np_fld};

   ////////////////////////////////////////////////////////////////////////////
   // preamble control register

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         r100 <= strap_r100;
      end else if (wr_mii) begin
         r100 <= bus.wdata[7];
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         r10 <= `R10_RST;
      end else if (wr_mii) begin
         r10 <= bus.wdata[6];
      end
   end

   // reserved bits hold constants and never take write data
   wire [15:0] mii_rdata = {`MII_RSVD_HI, r100, r10, `MII_RSVD_LO};

   ////////////////////////////////////////////////////////////////////////////
   // receive preamble filter

   wire [3:0] drop_100 = r100 ? `DROP_NONE : `DROP_100;
   wire [3:0] drop_10  = r10 ? `DROP_NONE : `DROP_10;
   wire [3:0] drop_now = SPEED_100_I ? drop_100 : drop_10;
   // drop count frozen at frame start: a mid-frame write cannot cut a frame
   wire [3:0] drop_sel = dv_d ? drop_lat : drop_now;
   wire       pass     = RX_DV_I & (nib_cnt >= drop_sel);
   wire       frm_end  = dv_d & ~RX_DV_I;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         dv_d <= 1'b0;
      end else begin
         dv_d <= RX_DV_I;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         drop_lat <= `DROP_NONE;
      end else if (RX_DV_I & ~dv_d) begin
         drop_lat <= drop_now;
      end
   end

   // saturates: nothing past the longest drop needs counting
   wire [3:0] nib_inc  = (nib_cnt == `NIB_MAX) ? nib_cnt : nib_cnt + 4'h1;
   wire [3:0] next_nib = RX_DV_I ? nib_inc : `DROP_NONE;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         nib_cnt <= `DROP_NONE;
      end else begin
         nib_cnt <= next_nib;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         MII_RX_DV_O <= 1'b0;
         MII_RXD_O   <= 4'h0;
         MII_RX_ER_O <= 1'b0;
      end else begin
         MII_RX_DV_O <= pass;
         MII_RXD_O   <= pass ? RXD_I : 4'h0;
         MII_RX_ER_O <= pass & RX_ER_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // errored-frame counter

   // a frame counts once however many error nibbles it carries
   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         err_seen <= 1'b0;
      end else begin
         err_seen <= RX_DV_I & (err_seen | RX_ER_I);
      end
   end

   wire        sym_inc  = frm_end & err_seen;
   // holds at all ones rather than wrapping to a small misleading count
   wire        sym_full = (sym_err == `SYM_ERR_MAX);
   wire [15:0] sym_up   = sym_full ? sym_err : sym_err + 16'h0001;
   wire [15:0] sym_base = rd_sym ? `SYM_ERR_RST : sym_err;
   // a frame ending in the read cycle survives the clear
   wire [15:0] sym_clr1 = {15'h0000, 1'b1};
   wire [15:0] sym_hold = sym_inc ? sym_up : sym_err;
   wire [15:0] sym_rdc  = sym_inc ? sym_clr1 : sym_base;
   wire [15:0] next_sym = rd_sym ? sym_rdc : sym_hold;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         sym_err <= `SYM_ERR_RST;
      end else begin
         sym_err <= next_sym;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt enables and event flags

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         irq_en <= `IRQ_EN_RST;
      end else if (wr_irq) begin
         irq_en <= bus.wdata[15:8];
      end
   end

   wire en_jab = irq_en[`IRQ_JAB];
   wire en_rxe = irq_en[`IRQ_RXE];
   wire en_pgr = irq_en[`IRQ_PGR];
   wire en_pdf = irq_en[`IRQ_PDF];
   wire en_lpa = irq_en[`IRQ_LPA];
   wire en_ldn = irq_en[`IRQ_LDN];
   wire en_rmf = irq_en[`IRQ_RMF];
   wire en_lup = irq_en[`IRQ_LUP];

   wire [7:0] en_mask = {en_jab, en_rxe, en_pgr, en_pdf, en_lpa, en_ldn, en_rmf, en_lup};
   wire [7:0] next_en = wr_irq ? bus.wdata[15:8] : irq_en;

   // flags latch even while disabled; enabling later raises the line at once
   wire [7:0] flg_keep  = rd_irq ? `IRQ_FLG_RST : irq_flg;
   wire [7:0] next_flg  = flg_keep | INT_EVENT_I;

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         irq_flg <= `IRQ_FLG_RST;
      end else begin
         irq_flg <= next_flg;
      end
   end

   wire next_irq = |(next_flg & next_en);

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         INTR_N_O <= 1'b1;
      end else begin
         INTR_N_O <= ~next_irq;
      end
   end

   wire [15:0] irq_rdata = {en_mask, irq_flg};

   ////////////////////////////////////////////////////////////////////////////
   // read data; unmapped addresses read zero

   wire [15:0] rd_np  = hit_np ? np_rdata : 16'h0000;
   wire [15:0] rd_mii = hit_mii ? mii_rdata : 16'h0000;
   wire [15:0] rd_sy  = hit_sym ? sym_err : 16'h0000;
   wire [15:0] rd_irq_w = hit_irq ? irq_rdata : 16'h0000;

   assign bus.rdata = rd_np | rd_mii | rd_sy | rd_irq_w;

endmodule // phy_nextpage_mii_irq_regs

// >>> rtl/phy_regs_defines.svh
`ifndef PHY_REGS_DEFINES_SVH
`define PHY_REGS_DEFINES_SVH
`define OFS_NP_WORD  5'h08
`define OFS_MII_CTL  5'h14
`define OFS_SYM_ERR  5'h15
`define OFS_IRQ_CTL  5'h1b
`define NP_ACK       14
`define NP_MSG       13
`define NP_ACK2      12
`define NP_TOG       11
`define NP_FLD_HI    10
`define MII_RSVD_HI  8'h00
`define MII_RSVD_LO  6'h01
`define STRAP_R100   3'h4
`define R10_RST      1'h0
`define NP_WORD_RST  16'h0000
`define SYM_ERR_RST  16'h0000
`define SYM_ERR_MAX  16'hffff
`define IRQ_EN_RST   8'h00
`define IRQ_FLG_RST  8'h00
`define IRQ_JAB      7
`define IRQ_RXE      6
`define IRQ_PGR      5
`define IRQ_PDF      4
`define IRQ_LPA      3
`define IRQ_LDN      2
`define IRQ_RMF      1
`define IRQ_LUP      0
`define DROP_NONE    4'h0
`define DROP_100     4'h2
`define DROP_10      4'he
`define NIB_MAX      4'hf
`define PRE_ONES     6'h20
`define OP_RD        2'h2
`define OP_WR        2'h1
`define HDR_LAST     5'h0b
`define TA_LAST      5'h01
`define DATA_LAST    5'h0f
`define RD_RELEASE   5'h10
`endif

// >>> rtl/phy_regs_pkg.sv
package phy_regs_pkg;
   typedef enum logic [2:0] {
      MS_IDLE  = 3'b000,
      MS_START = 3'b001,
      MS_HDR   = 3'b010,
      MS_TA    = 3'b011,
      MS_DATA  = 3'b100
   } mdio_state_e;
   typedef logic [15:0] reg_word_t;
   typedef logic [4:0]  reg_addr_t;
endpackage

// >>> verification/mgmt_station.sv
`timescale 1ns/1ns
module mgmt_station
   import phy_regs_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h01
) (
   input  wire logic clk_i,
   input  wire logic mdio_i,
   output logic      mdc_o,
   output logic      mdio_o,
   output logic      mdio_oe_o
);
   // clock stands low between frames
   initial begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
      mdio_oe_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one bit: data set in the low phase, sampled just before the rise
   task automatic bit_cyc(input logic oe, input logic d, output logic s);
      mdio_oe_o = oe;
      mdio_o = oe ? d : 1'b1;
      repeat (8) @(negedge clk_i);
      s = mdio_i;
      mdc_o = 1'b1;
      repeat (8) @(negedge clk_i);
      mdc_o = 1'b0;
   endtask
   task automatic xfer(input logic rd, input reg_addr_t ra, input reg_word_t wd, output reg_word_t rv);
      logic [31:0] hdr;
      logic        s;
      hdr = {2'b01, rd ? 2'b10 : 2'b01, PHY_ADDR, ra, rd ? 2'b11 : 2'b10, wd};
      rv = 16'h0000;
      for (int i = 0; i < 32; i++) begin
         bit_cyc(1'b1, 1'b1, s);
      end
      // on a read the turnaround and data are left to the device
      for (int i = 31; i >= 0; i--) begin
         bit_cyc(!(rd && i < 18), hdr[i], s);
         if (i < 16) begin
            rv[i] = s;
         end
      end
      mdio_oe_o = 1'b0;
      mdio_o = 1'b1;
   endtask
endmodule // mgmt_station

// >>> verification/phy_regs_properties.sv
`timescale 1ns/1ns
module phy_regs_properties (
   input wire logic       CLK_SYS_I,
   input wire logic       RESETN_I,
   input wire logic       MDC_I,
   input wire logic       MDIO_O,
   input wire logic       MDIO_OE_O,
   input wire logic       RX_DV_I,
   input wire logic [3:0] RXD_I,
   input wire logic       RX_ER_I,
   input wire logic       MII_RX_DV_O,
   input wire logic [3:0] MII_RXD_O,
   input wire logic       MII_RX_ER_O,
   input wire logic [7:0] INT_EVENT_I,
   input wire logic       INTR_N_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   logic [8:0] oe_cnt;
   // counts how long the device holds the data line
   always_ff @(posedge CLK_SYS_I) begin
      oe_cnt <= (!RESETN_I || !MDIO_OE_O) ? 9'h000 : oe_cnt + 9'h001;
   end
   ////////////////////////////////////////////////////////////////////////////
   a_dv_delayed: assert property (MII_RX_DV_O |-> $past(RX_DV_I))
      else $error("receive valid without input one cycle earlier");
   a_rxd_delayed: assert property (MII_RX_DV_O |-> MII_RXD_O == $past(RXD_I))
      else $error("receive nibble not the delayed input");
   a_er_delayed: assert property (MII_RX_ER_O |-> $past(RX_ER_I))
      else $error("receive error without input error");
   a_intr_cause: assert property ($fell(INTR_N_O) |-> $past(INT_EVENT_I) != 8'h00)
      else $error("interrupt raised without an event");
   a_intr_read_clear: assert property ($rose(INTR_N_O) |-> ##[4:40] MDIO_OE_O)
      else $error("interrupt released outside a read");
   a_intr_hold_idle: assert property ((!MDC_I) [*5] ##0 !INTR_N_O |=> !INTR_N_O)
      else $error("interrupt released with no bus activity");
   a_ta_drive_low: assert property ($rose(MDIO_OE_O) |-> !MDIO_O && $past(MDC_I, 2))
      else $error("turnaround not driven low after a clock rise");
   a_read_span: assert property ($fell(MDIO_OE_O) |-> oe_cnt inside {[270:274]})
      else $error("read drive span not seventeen bit periods");
   c_intr: cover property ($fell(INTR_N_O));
   c_read: cover property ($rose(MDIO_OE_O));
   c_rx: cover property ($rose(MII_RX_DV_O));
endmodule // phy_regs_properties
bind phy_nextpage_mii_irq_regs phy_regs_properties u_props (
   .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .MDC_I(MDC_I), .MDIO_O(MDIO_O), .MDIO_OE_O(MDIO_OE_O),
   .RX_DV_I(RX_DV_I), .RXD_I(RXD_I), .RX_ER_I(RX_ER_I), .MII_RX_DV_O(MII_RX_DV_O), .MII_RXD_O(MII_RXD_O),
   .MII_RX_ER_O(MII_RX_ER_O), .INT_EVENT_I(INT_EVENT_I), .INTR_N_O(INTR_N_O));

// >>> verification/testbench.sv
`timescale 1ns/1ns
module testbench;
   import phy_regs_pkg::*;
   logic        clk = 1'b0, rst_n, lp_vld, sp100, dv, er, mdc, st_d, st_oe, mdio_w;
   logic        mdio_o, mdio_oe, rx_dv_o, rx_er_o, intr_n;
   logic [2:0]  cfg;
   logic [3:0]  rxd, rxd_o;
   logic [7:0]  ev;
   logic [15:0] lp;
   logic [31:0] rnd;
   logic [4:0]  expq[$];
   integer      seed, bad_count = 0, checked = 0;
   always #2 clk = ~clk;
   // pulled-up line: idles high when nobody drives
   assign mdio_w = mdio_oe ? mdio_o : (st_oe ? st_d : 1'b1);
   phy_nextpage_mii_irq_regs #(.PHY_ADDR(5'h01)) u_dut (
      .CLK_SYS_I(clk), .RESETN_I(rst_n), .CONFIG_I(cfg), .MDC_I(mdc), .MDIO_I(mdio_w), .MDIO_O(mdio_o),
      .MDIO_OE_O(mdio_oe), .LP_PAGE_I(lp), .LP_PAGE_VLD_I(lp_vld), .SPEED_100_I(sp100), .RX_DV_I(dv),
      .RXD_I(rxd), .RX_ER_I(er), .MII_RX_DV_O(rx_dv_o), .MII_RXD_O(rxd_o), .MII_RX_ER_O(rx_er_o),
      .INT_EVENT_I(ev), .INTR_N_O(intr_n));
   mgmt_station #(.PHY_ADDR(5'h01)) u_st (.clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(st_d),
      .mdio_oe_o(st_oe));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd(input reg_addr_t a, input reg_word_t e);
      reg_word_t v;
      u_st.xfer(1'b1, a, 16'h0000, v);
      check(v, e);
   endtask
   task automatic wr(input reg_addr_t a, input reg_word_t d);
      reg_word_t v;
      u_st.xfer(1'b0, a, d, v);
   endtask
   task automatic do_reset(input logic [2:0] c);
      cfg = c;
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
   endtask
   task automatic pulse(input logic [7:0] v);
      @(negedge clk);
      ev = v;
      @(negedge clk);
      ev = 8'h00;
      @(negedge clk);
   endtask
   // dropped leading nibbles are never queued
   task automatic frame(input int drop, input logic [4:0] erpos);
      for (int i = 0; i < 20; i++) begin
         @(negedge clk);
         rnd = $random(seed);
         dv = 1'b1;
         rxd = rnd[3:0];
         er = (i == erpos);
         if (i >= drop) begin
            expq.push_back({er, rxd});
         end
      end
      @(negedge clk);
      dv = 1'b0;
      er = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   always @(negedge clk) begin
      if (rx_dv_o === 1'b1) begin
         check({11'h000, rx_er_o, rxd_o}, (expq.size() > 0) ? {11'h000, expq.pop_front()} : 16'hffff);
      end
   end
   task automatic tally_and_finish();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h2f4dc74e;
      {lp_vld, sp100, dv, er, rxd, lp, ev} = '0;
      do_reset(3'h4);
      rd(5'h14, 16'h0081);
      rd(5'h1b, 16'h0000);
      rd(5'h15, 16'h0000);
      rd(5'h08, 16'h0000);
      rd(5'h03, 16'h0000);
      rnd = $random(seed);
      @(negedge clk);
      lp = rnd[15:0];
      lp_vld = 1'b1;
      @(negedge clk);
      lp_vld = 1'b0;
      wr(5'h08, ~lp);
      rd(5'h08, lp);
      for (int m = 0; m < 4; m++) begin
         wr(5'h14, (m < 2) ? 16'hffff : 16'h0000);
         rd(5'h14, (m < 2) ? 16'h00c1 : 16'h0001);
         sp100 = m[0];
         frame((m < 2) ? 0 : (m[0] ? 2 : 14), (m == 1) ? 5'h1f : 5'h0f);
      end
      check(16'(expq.size()), 16'h0000);
      rd(5'h15, 16'h0003);
      rd(5'h15, 16'h0000);
      wr(5'h1b, 16'hffff);
      rd(5'h1b, 16'hff00);
      rnd = $random(seed);
      pulse(rnd[7:0] | 8'h01);
      check({15'h0000, intr_n}, 16'h0000);
      rd(5'h1b, {8'hff, rnd[7:0] | 8'h01});
      rd(5'h1b, 16'hff00);
      check({15'h0000, intr_n}, 16'h0001);
      wr(5'h1b, 16'h0000);
      pulse(8'hff);
      check({15'h0000, intr_n}, 16'h0001);
      rd(5'h1b, 16'h00ff);
      do_reset(3'h3);
      rd(5'h14, 16'h0001);
      tally_and_finish();
   end
   // generous bound: the sequence needs about a third of it
   initial begin
      #300000;
      bad_count++;
      tally_and_finish();
   end
endmodule // testbench
